// ### design/htwm_pkg.sv
// Package for the host timers and word mapping block
package htwm_pkg;
    localparam logic [7:0]  HTWM_OFF_TIMER_CONFIG = 8'h8c;
    localparam logic [7:0]  HTWM_OFF_TIMER_LIVE   = 8'h90;
    localparam logic [7:0]  HTWM_OFF_HALF_ORDER   = 8'h98;
    localparam logic [7:0]  HTWM_OFF_TICK_COUNT   = 8'h9c;
    localparam logic [7:0]  HTWM_OFF_DROP_TALLY   = 8'ha0;
    localparam int          HTWM_RUN_BIT          = 29;
    localparam logic [15:0] HTWM_PRELOAD_RST      = 16'hffff;
    localparam logic [15:0] HTWM_LIVE_RST         = 16'hffff;
    localparam logic [31:0] HTWM_ORDER_RST        = 32'h00000000;
    localparam logic [31:0] HTWM_ORDER_SWAP       = 32'hffffffff;
    localparam logic [31:0] HTWM_DROP_MID         = 32'h7fffffff;
    localparam int          HTWM_CLK_MHZ          = 125;
    localparam int          HTWM_TICK_MHZ         = 25;
    // Core cycles per 25 MHz tick
    localparam int          HTWM_TICK_DIV         = HTWM_CLK_MHZ / HTWM_TICK_MHZ;
    localparam logic [2:0]  HTWM_TICK_DIV_LAST    = 3'(HTWM_TICK_DIV - 1);
    localparam int          HTWM_CLEAR_NS         = 160;
    localparam int          HTWM_CLEAR_CYC        = HTWM_CLEAR_NS * HTWM_CLK_MHZ
                                                    / 1000;
    localparam logic [2:0]  HTWM_DIV_RST          = 3'h0;
endpackage : htwm_pkg

// ### design/htwm_top.sv
// Host timers, tick counter, drop tally and half-word order control
`timescale 1ns/10ps
module htwm_top
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_bus16,
    input  wire logic        i_cs,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [1:0]  i_power_state,
    input  wire logic        i_frame_dropped,
    input  wire logic [31:0] i_tx_word,
    input  wire logic        i_rx_lo_valid,
    input  wire logic        i_rx_hi_valid,
    input  wire logic [15:0] i_rx_half,
    output logic      [31:0] o_rdata,
    output logic             o_timer_event,
    output logic             o_drop_event,
    output logic      [15:0] o_tx_half_first,
    output logic      [15:0] o_tx_half_second,
    output logic      [31:0] o_rx_word
);
    import htwm_pkg::*;

    typedef struct packed {
        logic        run;
        logic [15:0] preload;
        logic [15:0] live;
        logic [31:0] order;
        logic [2:0]  div;
        logic [31:0] tick;
        logic [31:0] tick_snap;
        logic        snap_hi_pending;
        logic [31:0] drop;
        logic [31:0] rdata;
        logic        timer_ev;
        logic        drop_ev;
        logic [15:0] tx_first;
        logic [15:0] tx_second;
        logic [31:0] rx_word;
    } htwm_state_type;

    htwm_state_type st_q;
    htwm_state_type st_d;

    logic        acc_wr;
    logic        acc_rd;
    logic        swap16;
    logic        sel_high;
    logic [7:0]  word_addr;
    logic [31:0] wmerge;
    logic [31:0] rword;
    logic        tick_en;

    always_comb
    begin
        acc_wr    = i_cs && i_wr;
        acc_rd    = i_cs && i_rd && !i_wr;
        swap16    = (st_q.order == HTWM_ORDER_SWAP);
        sel_high  = i_bus16 && (i_addr[1] ^ swap16);
        word_addr = {i_addr[7:2], 2'b00};
        tick_en   = (st_q.div == HTWM_TICK_DIV_LAST);
        st_d      = st_q;
        st_d.timer_ev = 1'b0;
        st_d.drop_ev  = 1'b0;

        // Current register word, used for reads and half-word merges
        unique case (word_addr)
            HTWM_OFF_TIMER_CONFIG:
                rword = {2'b00, st_q.run, 13'h0000, st_q.preload};
            HTWM_OFF_TIMER_LIVE:
                rword = {16'h0000, st_q.live};
            HTWM_OFF_HALF_ORDER:
                rword = st_q.order;
            HTWM_OFF_TICK_COUNT:
                rword = st_q.snap_hi_pending ? st_q.tick_snap : st_q.tick;
            HTWM_OFF_DROP_TALLY:
                rword = st_q.drop;
            default:
                rword = 32'h00000000;
        endcase

        if (!i_bus16)
            wmerge = i_wdata;
        else if (sel_high)
            wmerge = {i_wdata[15:0], rword[15:0]};
        else
            wmerge = {rword[31:16], i_wdata[15:0]};

        if (acc_rd)
        begin
            if (!i_bus16)
                st_d.rdata = rword;
            else if (sel_high)
                st_d.rdata = {16'h0000, rword[31:16]};
            else
                st_d.rdata = {16'h0000, rword[15:0]};
        end

        st_d.div  = tick_en ? HTWM_DIV_RST : st_q.div + 3'h1;
        if (tick_en)
            st_d.tick = st_q.tick + 32'h00000001;

        if (acc_rd && i_bus16 && word_addr == HTWM_OFF_TICK_COUNT)
        begin
            if (!st_q.snap_hi_pending)
            begin
                st_d.tick_snap       = st_q.tick;
                st_d.snap_hi_pending = 1'b1;
            end
            else
                st_d.snap_hi_pending = 1'b0;
        end

        if (st_q.run && tick_en)
        begin
            if (st_q.live == 16'h0000)
            begin
                st_d.live     = st_q.preload;
                st_d.timer_ev = 1'b1;
            end
            else
                st_d.live = st_q.live - 16'h0001;
        end

        if (acc_wr && word_addr == HTWM_OFF_TIMER_CONFIG)
        begin
            st_d.run     = wmerge[HTWM_RUN_BIT];
            st_d.preload = wmerge[15:0];
            if (wmerge[HTWM_RUN_BIT] && !st_q.run)
                st_d.live = wmerge[15:0];
            if (st_q.run && !wmerge[HTWM_RUN_BIT])
                st_d.preload = HTWM_PRELOAD_RST;
        end

        if (acc_wr && word_addr == HTWM_OFF_HALF_ORDER)
            st_d.order = wmerge;

        // a 32-bit or high-half read clears, a drop in the same cycle counts as one
        if (acc_rd && word_addr == HTWM_OFF_DROP_TALLY
            && (!i_bus16 || sel_high))
            st_d.drop = i_frame_dropped ? 32'h00000001 : 32'h00000000;
        else if (i_frame_dropped)
        begin
            st_d.drop = st_q.drop + 32'h00000001;
            st_d.drop_ev = (st_q.drop == HTWM_DROP_MID);
        end

        // low half first on the network
        st_d.tx_first  = i_tx_word[15:0];
        st_d.tx_second = i_tx_word[31:16];
        if (i_rx_lo_valid)
            st_d.rx_word[15:0] = i_rx_half;
        if (i_rx_hi_valid)
            st_d.rx_word[31:16] = i_rx_half;
    end

    always_ff @(posedge i_clock)
    begin
        // synchronous clear, preload and live to ffff and the rest zero one edge after reset
        if (!i_rst_n)
        begin
            st_q                 <= '0;
            st_q.preload         <= HTWM_PRELOAD_RST;
            st_q.live            <= HTWM_LIVE_RST;
            st_q.order           <= HTWM_ORDER_RST;
            st_q.div             <= HTWM_DIV_RST;
        end
        else
            st_q <= st_d;
    end

    assign o_rdata          = st_q.rdata;
    assign o_timer_event    = st_q.timer_ev;
    assign o_drop_event     = st_q.drop_ev;
    assign o_tx_half_first  = st_q.tx_first;
    assign o_tx_half_second = st_q.tx_second;
    assign o_rx_word        = st_q.rx_word;

    // Cycles allowed for the tick counter to read zero after reset
    localparam int AST_CLR_WIN = HTWM_CLEAR_CYC;

    // Timer control and count
    AST_RUN_SET: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        acc_wr && word_addr == HTWM_OFF_TIMER_CONFIG && !i_bus16
        |=> st_q.run == $past(i_wdata[29]))
        else $error("run bit did not follow write");
    AST_IDLE_HOLD: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !st_q.run && !(acc_wr && word_addr == HTWM_OFF_TIMER_CONFIG)
        |=> st_q.live == $past(st_q.live))
        else $error("halted timer moved");
    AST_HALT_PRE: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        $fell(st_q.run) |-> st_q.preload == 16'hffff)
        else $error("preload not restored on halt");
    AST_START_LD: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        $rose(st_q.run) |-> st_q.live == st_q.preload)
        else $error("live count not loaded at start");
    AST_PRE_RST: assert property (
        @(posedge i_clock)
        $rose(i_rst_n) |-> st_q.preload == 16'hffff && st_q.live == 16'hffff)
        else $error("timer fields wrong after reset");
    AST_EXPIRE: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        st_q.run && tick_en && st_q.live == 16'h0000
        && !(acc_wr && word_addr == HTWM_OFF_TIMER_CONFIG)
        |=> o_timer_event && st_q.live == $past(st_q.preload))
        else $error("expiry did not reload and flag");
    AST_COUNT_DN: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        st_q.run && tick_en && st_q.live != 16'h0000
        && !(acc_wr && word_addr == HTWM_OFF_TIMER_CONFIG)
        |=> st_q.live == $past(st_q.live) - 16'h0001)
        else $error("timer did not count down");
    AST_EV_PULSE: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        o_timer_event |=> !o_timer_event)
        else $error("timer event longer than one cycle");
    AST_LIVE_RD: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        acc_rd && !i_bus16 && word_addr == HTWM_OFF_TIMER_LIVE
        |=> o_rdata == {16'h0000, $past(st_q.live)})
        else $error("live count read wrong");

    // Half-word mapping and network order
    AST_BUS32_MAP: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        acc_rd && !i_bus16 && word_addr == HTWM_OFF_HALF_ORDER
        |=> o_rdata == $past(st_q.order))
        else $error("32-bit read not mapped straight");
    AST_ORDER_WR: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        acc_wr && !i_bus16 && word_addr == HTWM_OFF_HALF_ORDER
        |=> st_q.order == $past(i_wdata))
        else $error("32-bit write not mapped straight");
    AST_HALF_MAP: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        acc_rd && i_bus16 && i_addr[1] && st_q.order != 32'hffffffff
        |=> o_rdata[15:0] == $past(rword[31:16]))
        else $error("high half not selected");
    AST_HALF_SWAP: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        acc_rd && i_bus16 && !i_addr[1] && st_q.order == 32'hffffffff
        && word_addr == HTWM_OFF_TIMER_CONFIG
        |=> o_rdata == {16'h0000, 2'b00, $past(st_q.run), 13'h0000})
        else $error("swapped half not selected");
    AST_TX_ORDER: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        1'b1 |=> o_tx_half_first == $past(i_tx_word[15:0])
        && o_tx_half_second == $past(i_tx_word[31:16]))
        else $error("transmit halves out of order");
    AST_RX_LOW: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        i_rx_lo_valid |=> o_rx_word[15:0] == $past(i_rx_half))
        else $error("received low half misplaced");
    AST_RX_HIGH: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        i_rx_hi_valid |=> o_rx_word[31:16] == $past(i_rx_half))
        else $error("received high half misplaced");

    // Tick counter: one step every fifth clock
    AST_TICK_RATE: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        tick_en |=> (st_q.tick == $past(st_q.tick) + 32'h00000001
        && !tick_en) ##1 !tick_en [*3] ##1 tick_en)
        else $error("tick counter rate wrong");
    AST_TICK_PWR: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        tick_en && i_power_state != 2'h0
        |=> st_q.tick == $past(st_q.tick) + 32'h00000001)
        else $error("tick counter stopped in low power");
    AST_SNAP_USE: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        acc_rd && i_bus16 && word_addr == HTWM_OFF_TICK_COUNT
        && st_q.snap_hi_pending
        |=> o_rdata[15:0] == ($past(sel_high) ? $past(st_q.tick_snap[31:16])
        : $past(st_q.tick_snap[15:0])))
        else $error("second half not from snapshot");
    AST_RST_CLR: assert property (
        @(posedge i_clock)
        $rose(i_rst_n) |-> ##[0:AST_CLR_WIN] st_q.tick == 32'h0)
        else $error("tick not cleared after reset");

    // Drop tally; the midpoint cannot be reached in a short run
    AST_DROP_INC: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        i_frame_dropped && !(acc_rd && word_addr == HTWM_OFF_DROP_TALLY)
        |=> st_q.drop == $past(st_q.drop) + 32'h00000001)
        else $error("drop count did not step");
    AST_DROP_CLR: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        acc_rd && !i_bus16 && word_addr == HTWM_OFF_DROP_TALLY
        |=> o_rdata == $past(st_q.drop)
        && st_q.drop == {31'h0, $past(i_frame_dropped)})
        else $error("drop read did not clear");
    AST_DROP_MID: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        o_drop_event |-> st_q.drop == 32'h80000000)
        else $error("midpoint event misplaced");
    AST_DROP_PULSE: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        o_drop_event |=> !o_drop_event)
        else $error("drop event longer than one cycle");

    COV_TIMER_EV: cover property (@(posedge i_clock) o_timer_event);
    COV_DROP_EV:  cover property (@(posedge i_clock) o_drop_event);
    COV_SPLIT_RD: cover property (@(posedge i_clock)
        st_q.snap_hi_pending ##1 !st_q.snap_hi_pending);
    COV_SWAP_RD:  cover property (@(posedge i_clock)
        acc_rd && i_bus16 && swap16);
endmodule : htwm_top

// ### dv/htwm_host_model.sv
// Host CPU model driving the SRAM-like register bus
`timescale 1ns/10ps
module htwm_host_model
(
    input  wire logic        i_clock,
    input  wire logic [31:0] i_rdata,
    output logic             o_cs,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [7:0]  o_addr,
    output logic      [31:0] o_wdata
);
    initial
    begin
        {o_cs, o_wr, o_rd, o_addr, o_wdata} = '0;
    end
    // One access per call; released address and data lines show the inverse of the last value, control lines go low
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clock);
        #1;
        {o_cs, o_wr, o_rd, o_addr, o_wdata} = {1'b1, w, ~w, a, d};
        @(posedge i_clock);
        #1;
        {o_cs, o_wr, o_rd, o_addr, o_wdata} = {3'b000, ~a, ~d};
        q = i_rdata;
    endtask : acc
endmodule : htwm_host_model

// ### dv/tb_host_timers_and_word_mapping.sv
// Self-checking testbench for the host timers and word mapping block
`timescale 1ns/10ps
module tb_host_timers_and_word_mapping;
    import htwm_pkg::*;
    logic        i_clock, i_rst_n, i_bus16, i_cs, i_wr, i_rd;
    logic        i_frame_dropped, i_rx_lo_valid, i_rx_hi_valid;
    logic [7:0]  i_addr;
    logic [1:0]  i_power_state;
    logic [15:0] i_rx_half, o_tx_half_first, o_tx_half_second;
    logic [31:0] i_wdata, i_tx_word, o_rdata, o_rx_word, rq, s;
    logic        o_timer_event, o_drop_event;
    int          num_errors, tests_run, n;

    htwm_host_model host (.i_clock(i_clock), .i_rdata(o_rdata),
        .o_cs(i_cs), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
        .o_wdata(i_wdata));
    htwm_top uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus16(i_bus16),
        .i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_power_state(i_power_state),
        .i_frame_dropped(i_frame_dropped), .i_tx_word(i_tx_word),
        .i_rx_lo_valid(i_rx_lo_valid), .i_rx_hi_valid(i_rx_hi_valid),
        .i_rx_half(i_rx_half), .o_rdata(o_rdata),
        .o_timer_event(o_timer_event), .o_drop_event(o_drop_event),
        .o_tx_half_first(o_tx_half_first),
        .o_tx_half_second(o_tx_half_second), .o_rx_word(o_rx_word));

    initial
    begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.acc(1'b1, a, d, rq);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        host.acc(1'b0, a, 32'h0, rq);
    endtask : rd

    task automatic tick(input int c);
        repeat (c) @(posedge i_clock);
        #1;
    endtask : tick

    task automatic test_regs;
        rd(HTWM_OFF_TICK_COUNT);
        chk(32'(rq <= 32'h1), 32'h1);
        rd(HTWM_OFF_TIMER_CONFIG);
        chk(rq, 32'h0000ffff);
        wr(HTWM_OFF_TIMER_LIVE, 32'h0);
        rd(HTWM_OFF_TIMER_LIVE);
        chk(rq, 32'h0000ffff);
        rd(HTWM_OFF_HALF_ORDER);
        chk(rq, 32'h0);
        rd(8'ha4);
        chk(rq, 32'h0);
        $display("test regs done");
    endtask : test_regs

    // Event spacing: four 5-cycle ticks from preload 3 back to expiry
    task automatic test_timer;
        wr(HTWM_OFF_TIMER_CONFIG, 32'h20000003);
        rd(HTWM_OFF_TIMER_CONFIG);
        chk(rq, 32'h20000003);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            do begin tick(1); n++; end
            while (o_timer_event !== 1'b1 && n < 300);
        end
        chk(n, 32'd20);
        wr(HTWM_OFF_TIMER_CONFIG, 32'h00001234);
        rd(HTWM_OFF_TIMER_CONFIG);
        chk(rq, 32'h0000ffff);
        $display("test timer done");
    endtask : test_timer

    task automatic test_order;
        wr(HTWM_OFF_TIMER_CONFIG, 32'h00001234);
        wr(HTWM_OFF_HALF_ORDER, HTWM_ORDER_SWAP);
        rd(HTWM_OFF_TIMER_CONFIG);
        chk(rq, 32'h00001234);
        i_bus16 = 1'b1;
        rd(8'h8e);
        chk(rq, 32'h1234);
        rd(8'h8c);
        chk(rq, 32'h0);
        wr(8'h98, 32'h0);
        wr(8'h9a, 32'h0);
        rd(8'h8e);
        chk(rq, 32'h0);
        rd(8'h8c);
        chk(rq, 32'h1234);
        rd(8'h9c);
        s = rq;
        tick(50);
        rd(8'h9c);
        chk(rq, s);
        i_bus16 = 1'b0;
        $display("test order done");
    endtask : test_order

    // Reads taken exactly 100 clocks apart span twenty 25 MHz ticks
    task automatic test_tick;
        rd(HTWM_OFF_TICK_COUNT);
        s = rq;
        i_power_state = 2'h2;
        tick(98);
        rd(HTWM_OFF_TICK_COUNT);
        chk(rq - s, 32'd20);
        $display("test tick done");
    endtask : test_tick

    task automatic test_drop;
        repeat (3)
        begin
            i_frame_dropped = 1'b1;
            tick(1);
            i_frame_dropped = 1'b0;
            tick(1);
        end
        chk(32'(o_drop_event), 32'h0);
        rd(HTWM_OFF_DROP_TALLY);
        chk(rq, 32'h3);
        rd(HTWM_OFF_DROP_TALLY);
        chk(rq, 32'h0);
        $display("test drop done");
    endtask : test_drop

    task automatic test_data;
        wr(HTWM_OFF_HALF_ORDER, HTWM_ORDER_SWAP);
        {i_tx_word, i_rx_lo_valid, i_rx_half} = {32'haaaa5555, 17'h11111};
        tick(1);
        {i_rx_lo_valid, i_rx_hi_valid, i_rx_half} = {2'b01, 16'h2222};
        chk({o_tx_half_second, o_tx_half_first}, 32'haaaa5555);
        tick(1);
        i_rx_hi_valid = 1'b0;
        chk(o_rx_word, 32'h22221111);
        $display("test data done");
    endtask : test_data

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    initial
    begin
        #200000;
        num_errors++;
        complete_run();
    end

    initial
    begin
        {i_rst_n, i_bus16, i_frame_dropped, i_rx_lo_valid} = '0;
        {i_rx_hi_valid, i_rx_half, i_power_state, i_tx_word} = '0;
        {num_errors, tests_run} = '0;
        tick(12);
        i_rst_n = 1'b1;
        test_regs();
        test_timer();
        test_order();
        test_tick();
        test_drop();
        test_data();
        complete_run();
    end
endmodule : tb_host_timers_and_word_mapping
